/* File: hdl/mtc_core.sv */
// Three-channel timer core: enables, flags, counters, compare/capture regs
// Behaviour
// - Per-channel 8-bit enable register, reset 0x40
// - Bit 7 gates A/D request on A events
// - Bit 6 reads 1, bit 5 reads 0
// - Bit 4 enables overflow interrupt request
// - Bit 3 enables D interrupt, channel 0 only
// - Bit 2 enables C interrupt, channel 0 only
// - Bit 1 enables B interrupt, all channels
// - Bit 0 enables A interrupt, all channels
// - Per-channel 8-bit status register, reset 0xC0
// - Overflow flag set on counter wrap to zero
// - Flags clear by read-one then write-zero
// - Flag D set on channel 0 D match
// - Flag C set on C match or capture
// - Flag B set on B compare match
// - Flag A set on A match or capture
// - Capture copies counter into general register
// - Three 16-bit up-counters, reset zero
// - Eight general regs, compare or capture each
// - Channel 0 C buffers A, D buffers B
// - General registers reset to all ones
`timescale 1ns/1ps
module mtc_core (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // Register port (16-bit words)
  input  wire mtc_pkg::mtc_bus_type   bus,
  output logic [15:0]                 rdata,
  // Counter run and capture event inputs (pins, synchronised here)
  input  wire logic [2:0]             count_en,
  input  wire logic [7:0]             capture_in,
  // Interrupt requests to the interrupt controller
  output logic [2:0]                  overflow_irq,
  output logic [2:0]                  match_a_irq,
  output logic [2:0]                  match_b_irq,
  output logic                        match_c_irq,
  output logic                        match_d_irq,
  // Conversion start requests to the A/D converter
  output logic [2:0]                  adc_start
);
  // Synchronised pin inputs
  logic [7:0]  cap_s1_ff;
  logic [7:0]  cap_s2_ff;
  logic [7:0]  cap_s3_ff;
  logic [2:0]  run_s1_ff;
  logic [2:0]  run_s2_ff;
  logic [7:0]  cap_evt;
  logic [7:0]  cmp_evt;
  logic [7:0]  ier_ff [3];
  logic [7:0]  sr_ff [3];
  logic [7:0]  seen_ff [3];
  logic [15:0] cnt_ff [3];
  logic [15:0] gr_ff [8];
  // Capture mode per general register, buffer mode for channel 0
  logic [7:0]  cap_mode_ff;
  logic [1:0]  buf_mode_ff;
  logic [7:0]  set_sr [3];
  logic [2:0]  ovf_evt;
  logic [15:0] nxt_rdata;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cap_s1_ff <= 8'h00;
      cap_s2_ff <= 8'h00;
      cap_s3_ff <= 8'h00;
      run_s1_ff <= 3'h0;
      run_s2_ff <= 3'h0;
    end else begin
      cap_s1_ff <= capture_in;
      cap_s2_ff <= cap_s1_ff;
      cap_s3_ff <= cap_s2_ff;
      run_s1_ff <= count_en;
      run_s2_ff <= run_s1_ff;
    end
  end

  // Channel of general register g: 0..3 ch0, 4..5 ch1, 6..7 ch2
  function automatic int unsigned gr_ch(input int unsigned g);
    return (g < 4) ? 0 : ((g < 6) ? 1 : 2);
  endfunction

  // Rising-edge capture, or match while counting in compare mode
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_evt
      // In buffer mode C/D only feed A/B, so they raise no own event
      logic bufd;
      if (g == 2 || g == 3) begin : g_bf
        assign bufd = buf_mode_ff[g-2];
      end else begin : g_nb
        assign bufd = 1'b0;
      end
      assign cap_evt[g] = cap_mode_ff[g] & ~bufd
                          & cap_s2_ff[g] & ~cap_s3_ff[g];
      assign cmp_evt[g] = ~cap_mode_ff[g] & ~bufd & run_s2_ff[gr_ch(g)]
                          & (cnt_ff[gr_ch(g)] == gr_ff[g]);
    end
  endgenerate

  // Counters count while enabled; a word write takes priority
  genvar c;
  generate
    for (c = 0; c < 3; c++) begin : g_ch
      localparam logic [4:0] CNT_OFS = mtc_pkg::OFS_CNT0 + 5'(c);
      localparam logic [4:0] IER_OFS = mtc_pkg::OFS_IER0 + 5'(c);
      localparam logic [4:0] SR_OFS  = mtc_pkg::OFS_SR0 + 5'(c);
      localparam logic [7:0] WM = (c == 0) ? mtc_pkg::IER_WM0
                                           : mtc_pkg::IER_WM12;
      localparam logic [7:0] FM = (c == 0) ? mtc_pkg::SR_FM0
                                           : mtc_pkg::SR_FM12;
      localparam int unsigned GA = (c == 0) ? 0 : 2 * c + 2;
      logic sr_rd;
      logic sr_wr;
      assign ovf_evt[c] = run_s2_ff[c] & (cnt_ff[c] == mtc_pkg::CNT_MAX);
      always_comb begin
        set_sr[c] = 8'h00;
        set_sr[c][mtc_pkg::BIT_OVF] = ovf_evt[c];
        set_sr[c][mtc_pkg::BIT_A] = cap_evt[GA] | cmp_evt[GA];
        set_sr[c][mtc_pkg::BIT_B] = cmp_evt[GA+1];
        if (c == 0) begin
          set_sr[c][mtc_pkg::BIT_C] = cap_evt[2] | cmp_evt[2];
          set_sr[c][mtc_pkg::BIT_D] = cmp_evt[3];
        end
      end
      assign sr_rd = bus.rd & (bus.addr == SR_OFS);
      assign sr_wr = bus.wr & (bus.addr == SR_OFS);

      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          cnt_ff[c] <= mtc_pkg::CNT_RST;
        end else if (bus.wr && bus.addr == CNT_OFS) begin
          cnt_ff[c] <= bus.wdata;
        end else if (run_s2_ff[c]) begin
          cnt_ff[c] <= cnt_ff[c] + 16'h0001;
        end
      end

      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          ier_ff[c] <= mtc_pkg::IER_RST;
        end else if (bus.wr && bus.addr == IER_OFS) begin
          // Fixed bits kept regardless of the written value
          ier_ff[c] <= (bus.wdata[7:0] & WM)
                       | mtc_pkg::IER_RST;
        end
      end

      // A flag clears only if it was read as one before the zero write;
      // a new event in the same cycle wins over the clear
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          sr_ff[c]   <= mtc_pkg::SR_RST;
          seen_ff[c] <= 8'h00;
        end else begin
          if (sr_wr) begin
            sr_ff[c] <= ((sr_ff[c] & ~(seen_ff[c] & ~bus.wdata[7:0]))
                         | set_sr[c]) & FM | mtc_pkg::SR_RST;
            seen_ff[c] <= 8'h00;
          end else begin
            sr_ff[c] <= (sr_ff[c] | set_sr[c]) & FM | mtc_pkg::SR_RST;
            if (sr_rd) begin
              seen_ff[c] <= sr_ff[c] & FM;
            end
          end
        end
      end

      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          overflow_irq[c] <= 1'b0;
          match_a_irq[c]  <= 1'b0;
          match_b_irq[c]  <= 1'b0;
          adc_start[c]    <= 1'b0;
        end else begin
          overflow_irq[c] <= sr_ff[c][mtc_pkg::BIT_OVF]
                             & ier_ff[c][mtc_pkg::BIT_OVF];
          match_a_irq[c]  <= sr_ff[c][mtc_pkg::BIT_A]
                             & ier_ff[c][mtc_pkg::BIT_A];
          match_b_irq[c]  <= sr_ff[c][mtc_pkg::BIT_B]
                             & ier_ff[c][mtc_pkg::BIT_B];
          // One pulse per A capture or match
          adc_start[c]    <= (cap_evt[GA] | cmp_evt[GA])
                             & ier_ff[c][mtc_pkg::BIT_ADC];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      match_c_irq <= 1'b0;
      match_d_irq <= 1'b0;
    end else begin
      match_c_irq <= sr_ff[0][mtc_pkg::BIT_C]
                     & ier_ff[0][mtc_pkg::BIT_C];
      match_d_irq <= sr_ff[0][mtc_pkg::BIT_D]
                     & ier_ff[0][mtc_pkg::BIT_D];
    end
  end

  // Mode register: bits 7:0 capture select, bits 9:8 buffer C/D
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cap_mode_ff <= 8'h00;
      buf_mode_ff <= 2'h0;
    end else if (bus.wr && bus.addr == mtc_pkg::OFS_CFG) begin
      cap_mode_ff <= bus.wdata[7:0];
      buf_mode_ff <= bus.wdata[9:8];
    end
  end

  // General registers; a bus write loses to a same-cycle hardware update
  generate
    for (g = 0; g < 8; g++) begin : g_gr
      localparam logic [4:0] GR_OFS = mtc_pkg::OFS_GR0 + 5'(g);
      logic        hw_load;
      logic [15:0] hw_val;
      if (g < 2) begin : g_ab
        // Buffered A/B reload from C/D on each compare match
        assign hw_load = cap_evt[g] | (buf_mode_ff[g] & cmp_evt[g]);
        assign hw_val  = cap_evt[g] ? cnt_ff[0] : gr_ff[g+2];
      end else if (g < 4) begin : g_cd
        // A capture on A/B pushes the value it replaces into C/D
        logic push;
        assign push    = buf_mode_ff[g-2] & cap_evt[g-2];
        assign hw_load = push | cap_evt[g];
        assign hw_val  = push ? gr_ff[g-2] : cnt_ff[0];
      end else begin : g_12
        assign hw_load = cap_evt[g];
        assign hw_val  = cnt_ff[gr_ch(g)];
      end
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          gr_ff[g] <= mtc_pkg::GR_RST;
        end else if (hw_load) begin
          gr_ff[g] <= hw_val;
        end else if (bus.wr && bus.addr == GR_OFS) begin
          gr_ff[g] <= bus.wdata;
        end
      end
    end
  endgenerate

  // Read mux: one word per index, unmapped reads return zero
  always_comb begin
    nxt_rdata = 16'h0000;
    for (int i = 0; i < 3; i++) begin
      if (bus.addr == mtc_pkg::OFS_IER0 + 5'(i)) begin
        nxt_rdata = {8'h00, ier_ff[i]};
      end
      if (bus.addr == mtc_pkg::OFS_SR0 + 5'(i)) begin
        nxt_rdata = {8'h00, sr_ff[i]};
      end
      if (bus.addr == mtc_pkg::OFS_CNT0 + 5'(i)) begin
        nxt_rdata = cnt_ff[i];
      end
    end
    for (int i = 0; i < 8; i++) begin
      if (bus.addr == mtc_pkg::OFS_GR0 + 5'(i)) begin
        nxt_rdata = gr_ff[i];
      end
    end
    if (bus.addr == mtc_pkg::OFS_CFG) begin
      nxt_rdata = {6'h00, buf_mode_ff, cap_mode_ff};
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (bus.rd) begin
      rdata <= nxt_rdata;
    end
  end

  // Assertions
  a_irq_ovf_and: assert property (@(posedge clk_sys) disable iff (rst)
    overflow_irq[0] == $past(sr_ff[0][4] & ier_ff[0][4]))
    else $error("overflow request not flag and enable");
  a_ier_fixed_bits: assert property (@(posedge clk_sys) disable iff (rst)
    ier_ff[1][6] && !ier_ff[1][5] && ier_ff[1][3:2] == 2'b00)
    else $error("enable register fixed bits wrong");
  a_sr_fixed_bits: assert property (@(posedge clk_sys) disable iff (rst)
    sr_ff[2][7:6] == 2'b11 && sr_ff[2][3:2] == 2'b00)
    else $error("status register fixed bits wrong");
  a_ovf_wrap_set: assert property (@(posedge clk_sys) disable iff (rst)
    ovf_evt[1] && !(bus.wr && bus.addr == mtc_pkg::OFS_CNT0 + 5'h01)
    |=> sr_ff[1][4] && cnt_ff[1] == mtc_pkg::CNT_RST)
    else $error("overflow flag not set on wrap");
  a_flag_hold: assert property (@(posedge clk_sys) disable iff (rst)
    sr_ff[0][0] && !(bus.wr && bus.addr == 5'h03) |=> sr_ff[0][0])
    else $error("flag cleared without write");
  a_clear_needs_read: assert property (@(posedge clk_sys)
    disable iff (rst)
    bus.wr && bus.addr == mtc_pkg::OFS_SR0 && !seen_ff[0][0] && sr_ff[0][0]
    |=> sr_ff[0][0])
    else $error("flag cleared without prior read");
  a_capture_copy: assert property (@(posedge clk_sys) disable iff (rst)
    cap_evt[5] |=> gr_ff[5] == $past(cnt_ff[1]))
    else $error("capture did not copy counter");
  a_adc_gate: assert property (@(posedge clk_sys) disable iff (rst)
    (cap_evt[0] || cmp_evt[0]) && ier_ff[0][7] |=> adc_start[0])
    else $error("A/D request missing");
  a_match_b_flag: assert property (@(posedge clk_sys) disable iff (rst)
    cmp_evt[5] |=> sr_ff[1][1])
    else $error("match B flag not set");
endmodule

/* File: hdl/mtc_pkg.sv */
// Package: register map, field layouts and types for the timer channel core
package mtc_pkg;
  localparam int unsigned NUM_CH = 3;
  localparam int unsigned NUM_GR = 8;
  // Register indices on the 16-bit register port
  localparam logic [4:0] OFS_IER0 = 5'h00;
  localparam logic [4:0] OFS_SR0  = 5'h03;
  localparam logic [4:0] OFS_CNT0 = 5'h06;
  localparam logic [4:0] OFS_CFG  = 5'h09;
  localparam logic [4:0] OFS_GR0  = 5'h10;
  // Field positions
  localparam int unsigned BIT_ADC  = 7;
  localparam int unsigned BIT_ONE  = 6;
  localparam int unsigned BIT_ZERO = 5;
  localparam int unsigned BIT_OVF  = 4;
  localparam int unsigned BIT_D    = 3;
  localparam int unsigned BIT_C    = 2;
  localparam int unsigned BIT_B    = 1;
  localparam int unsigned BIT_A    = 0;
  // Reset values
  localparam logic [7:0]  IER_RST  = 8'h40;
  localparam logic [7:0]  SR_RST   = 8'hC0;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  localparam logic [15:0] GR_RST   = 16'hFFFF;
  // Writable enables: full set on channel 0, only A/D, A/B and overflow elsewhere
  localparam logic [7:0]  IER_WM0  = 8'h9F;
  localparam logic [7:0]  IER_WM12 = 8'h93;
  localparam logic [7:0]  SR_FM0   = 8'h1F;
  localparam logic [7:0]  SR_FM12  = 8'h13;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } mtc_bus_type;
endpackage

/* File: dv/mtc_far_end.sv */
// Far-end model: A/D converter counting conversion start requests
`timescale 1ns/1ps
module mtc_far_end (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // Start requests from the timer
  input wire logic [2:0] adc_start
);
  int n_start [3];

  // A request is a one-cycle pulse, so each high cycle counts once
  always @(posedge clk_sys or posedge rst) begin
    for (int i = 0; i < 3; i++) begin
      if (rst) begin
        n_start[i] <= 0;
      end else if (adc_start[i]) begin
        n_start[i] <= n_start[i] + 1;
      end
    end
  end
endmodule

/* File: dv/timer_channel_flags_and_compare_regs_test.sv */
// Self-checking bench for the timer channel core
`timescale 1ns/1ps
module timer_channel_flags_and_compare_regs_test;
  logic                 clk_sys;
  logic                 rst;
  mtc_pkg::mtc_bus_type bus;
  logic [15:0]          rdata;
  logic [2:0]           count_en;
  logic [7:0]           capture_in;
  logic [2:0]           ovf_irq;
  logic [2:0]           a_irq;
  logic [2:0]           b_irq;
  logic                 c_irq;
  logic                 d_irq;
  logic [2:0]           adc_start;
  logic [15:0]          v;
  int                   n_fail;
  int                   compares;
  int                   ier [3];

  mtc_core u_mtc_core (.clk_sys(clk_sys), .rst(rst), .bus(bus),
    .rdata(rdata), .count_en(count_en), .capture_in(capture_in),
    .overflow_irq(ovf_irq), .match_a_irq(a_irq), .match_b_irq(b_irq),
    .match_c_irq(c_irq), .match_d_irq(d_irq), .adc_start(adc_start));
  mtc_far_end u_mtc_far_end (.clk_sys(clk_sys), .rst(rst),
    .adc_start(adc_start));

  task automatic give_verdict();
    $display("Compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Whole-word accesses only; one idle cycle between strobes
  task automatic wr(logic [4:0] a, logic [15:0] d);
    @(negedge clk_sys);
    bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys);
    bus.wr = 1'b0;
  endtask

  task automatic rc(string what, logic [4:0] a, int e);
    @(negedge clk_sys);
    bus.addr = a;
    bus.rd = 1'b1;
    @(negedge clk_sys);
    bus.rd = 1'b0;
    chk(what, rdata, 16'(e));
  endtask

  // Model of the enable register: masked bits, bit 6 forced high
  task automatic wier(int ch, logic [15:0] d);
    wr(5'(mtc_pkg::OFS_IER0 + ch), d);
    ier[ch] = (d & (ch == 0 ? mtc_pkg::IER_WM0 : mtc_pkg::IER_WM12))
              | mtc_pkg::IER_RST;
  endtask

  // Held three cycles so the pin synchroniser sees the edge
  task automatic cap(int i);
    @(negedge clk_sys);
    capture_in[i] = 1'b1;
    repeat (3) @(negedge clk_sys);
    capture_in[i] = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end

  initial begin
    bus = '0;
    count_en = '0;
    capture_in = '0;
    rst = 1'b1;
    n_fail = 0;
    compares = 0;
    v = 16'($urandom(24));
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    for (int i = 0; i < 3; i++) begin
      rc("ier", 5'(mtc_pkg::OFS_IER0 + i), 'h40);
      rc("sr", 5'(mtc_pkg::OFS_SR0 + i), 'hC0);
      rc("cnt", 5'(mtc_pkg::OFS_CNT0 + i), 0);
    end
    for (int i = 0; i < 8; i++) begin
      rc("gr", 5'(mtc_pkg::OFS_GR0 + i), 'hFFFF);
    end
    for (int k = 0; k < 12; k++) begin
      // Software keeps bit 6 at 1 and bit 5 at 0 in every write
      wier(k % 3, 16'(($urandom_range(255) & 'h9F) | 'h40));
      rc("ier rnd", 5'(k % 3), ier[k % 3]);
    end
    wr(mtc_pkg::OFS_CFG, 16'h0005);
    wier(0, 16'h009F);
    wier(1, 16'h0093);
    wier(2, 16'h0000);
    wr(mtc_pkg::OFS_CNT0, 16'h1234);
    cap(0);
    rc("gr a", mtc_pkg::OFS_GR0, 'h1234);
    rc("sr0 a", mtc_pkg::OFS_SR0, 'hC1);
    chk("irq a", 16'(a_irq), 16'h0001);
    chk("adc", 16'(u_mtc_far_end.n_start[0]), 16'h0001);
    // Any status write drops the read arming, so this 0 must not stick
    wr(mtc_pkg::OFS_SR0, 16'h00FF);
    wr(mtc_pkg::OFS_SR0, 16'h00FE);
    rc("sr0 keep", mtc_pkg::OFS_SR0, 'hC1);
    wr(mtc_pkg::OFS_SR0, 16'h00FE);
    rc("sr0 clr", mtc_pkg::OFS_SR0, 'hC0);
    chk("irq a off", 16'(a_irq), 16'h0000);
    wier(0, 16'h001F);
    cap(0);
    chk("adc gated", 16'(u_mtc_far_end.n_start[0]), 16'h0001);
    rc("sr0 a2", mtc_pkg::OFS_SR0, 'hC1);
    wr(mtc_pkg::OFS_SR0, 16'h00FE);
    wr(5'(mtc_pkg::OFS_GR0 + 1), 16'h0010);
    wr(5'(mtc_pkg::OFS_GR0 + 3), 16'h0012);
    wr(mtc_pkg::OFS_CNT0, 16'h0000);
    count_en[0] = 1'b1;
    repeat (40) @(negedge clk_sys);
    count_en[0] = 1'b0;
    rc("sr0 bd", mtc_pkg::OFS_SR0, 'hCA);
    chk("irq b", 16'(b_irq), 16'h0001);
    chk("irq d", 16'(d_irq), 16'h0001);
    cap(2);
    rc("sr0 c", mtc_pkg::OFS_SR0, 'hCE);
    chk("irq c", 16'(c_irq), 16'h0001);
    // Channel 1 A and B stay 0xFFFF, so they match on the way through
    wr(5'(mtc_pkg::OFS_CNT0 + 1), 16'hFFFE);
    count_en[1] = 1'b1;
    repeat (8) @(negedge clk_sys);
    count_en[1] = 1'b0;
    rc("sr1 ovf", 5'(mtc_pkg::OFS_SR0 + 1), 'hD3);
    chk("irq ovf", 16'(ovf_irq), 16'h0002);
    chk("adc ch1", 16'(u_mtc_far_end.n_start[1]), 16'h0001);
    wr(mtc_pkg::OFS_CFG, 16'h0105);
    wr(mtc_pkg::OFS_CNT0, 16'h1111);
    cap(0);
    wr(mtc_pkg::OFS_CNT0, 16'h2222);
    cap(0);
    rc("buf a", mtc_pkg::OFS_GR0, 'h2222);
    rc("buf c", 5'(mtc_pkg::OFS_GR0 + 2), 'h1111);
    // Channel 1 B switched to capture, counter preset with a random word
    wr(mtc_pkg::OFS_CFG, 16'h0125);
    wr(5'(mtc_pkg::OFS_CNT0 + 1), v);
    cap(5);
    rc("gr ch1 b", 5'(mtc_pkg::OFS_GR0 + 5), v);
    give_verdict();
  end
endmodule
